//--- include/ahc_pkg.sv
// package: shared types and constants of the host command checker
package ahc_pkg;

   // command symbols as decoded by the frame parser
   typedef enum logic [3:0] {
      CMD_BIT_READ,
      CMD_WORD_READ,
      CMD_BIT_WRITE,
      CMD_WORD_WRITE,
      CMD_EXT_READ_A,
      CMD_EXT_READ_B,
      CMD_EXT_WRITE_A,
      CMD_EXT_WORD_WRITE_B,
      CMD_LINK_TEST,
      CMD_ILLEGAL
   } ahc_cmd_t;

   // addressed device area
   typedef enum logic [1:0] {
      AREA_STATUS_BIT,
      AREA_CURRENT,
      AREA_CONSTANT
   } ahc_area_t;

   // recipe change kind carried by a write
   typedef enum logic [1:0] {
      RCP_NONE,
      RCP_MEASURE,
      RCP_DISPLAY,
      RCP_OUTPUT
   } ahc_rcp_t;

   // one parsed request
   typedef struct packed {
      logic [7:0]  sum_rx;
      logic [7:0]  sum_calc;
      ahc_cmd_t    cmd;
      ahc_area_t   area;
      logic [11:0] addr;
      logic [7:0]  count;
      ahc_rcp_t    rcp_kind;
      logic [7:0]  rcp_num;
   } ahc_req_t;

   // one verdict
   typedef struct packed {
      logic       err;
      logic [7:0] code;
   } ahc_rsp_t;

   // error codes
   localparam logic [7:0] ERR_NONE      = 8'h00;
   localparam logic [7:0] ERR_CHECKSUM  = 8'h01;
   localparam logic [7:0] ERR_COMMAND   = 8'h02;
   localparam logic [7:0] ERR_RANGE     = 8'h03;
   localparam logic [7:0] ERR_STAT_WR   = 8'h04;
   localparam logic [7:0] ERR_ODD_COUNT = 8'h05;
   localparam logic [7:0] ERR_ODD_ADDR  = 8'h06;
   localparam logic [7:0] ERR_MEAS_REG  = 8'h07;
   localparam logic [7:0] ERR_DISP_REG  = 8'h08;
   localparam logic [7:0] ERR_OUT_REG   = 8'h09;
   localparam logic [7:0] ERR_DISP_MEAS = 8'h0A;
   localparam logic [7:0] ERR_OUT_MEAS  = 8'h0B;

   // highest device number per area
   localparam logic [11:0] MAX_STATUS_BIT = 12'h04F;
   localparam logic [11:0] MAX_CURRENT    = 12'h0A0;
   localparam logic [11:0] MAX_CONSTANT   = 12'h92A;

   // link setup and host send wait
   localparam int BAUD_BPS       = 38400;
   localparam int DATA_BITS      = 8;
   localparam int STOP_BITS      = 1;
   localparam int CLK_HZ         = 100_000_000;
   localparam int SEND_WAIT_MS   = 20;
   localparam int SEND_WAIT_CYC  = SEND_WAIT_MS * (CLK_HZ / 1000);
endpackage

//--- rtl/ahc_checker.sv
// module: validation of parsed host requests and error code reply
`timescale 1ns/1ps

// Functional notes
// RL1: bad checksum gives code 01
// RL2: unknown command symbol gives code 02
// RL3: device number beyond range gives 03
// RL4: word write to status bits gives 04
// RL5: odd word device count gives 05
// RL6: odd starting word address gives 06
// RL7: unregistered measure recipe gives 07
// RL8: unregistered display recipe gives 08
// RL9: unregistered output recipe gives 09
// RL10: display recipe not measured gives 0A
// RL11: output recipe not measured gives 0B
// RL12: status bits never written by host
// RL13: even addresses and counts only
// RL14: link 38400 8N1 with ER control
// RL15: host waits 20 ms between transfers
// RL16: fixed check order, first error only
// RL17: error code replaces reply payload
module ahc_checker #(
   parameter int RECIPES = 256
)(
   // clock, reset, enable
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             clk_en_i,
   // request from frame parser
   input  wire logic             req_valid_i,
   input  wire ahc_pkg::ahc_req_t req_i,
   // recipe state from measurement logic
   input  wire logic             rcp_wr_valid_i,
   input  wire logic [7:0]       rcp_wr_num_i,
   input  wire logic [RECIPES-1:0] rcp_measuring_i,
   // verdict to reply builder
   output logic                  rsp_valid_o,
   output ahc_pkg::ahc_rsp_t     rsp_o,
   // device access grant
   output logic                  access_go_o,
   output logic                  stat_wr_o
);

   // elaboration check
   if (RECIPES < 1 || RECIPES > 256)
   begin : g_bad
      $error("RECIPES must be 1 to 256");
   end

   // recipe registration flags, one per recipe number
   logic [RECIPES-1:0] registered_ff;
   logic [RECIPES-1:0] nxt_registered;

   // reply registers
   logic              rsp_valid_ff;
   ahc_pkg::ahc_rsp_t rsp_ff;
   logic              go_ff;

   // word write decode, used by the status check and the write class
   function automatic logic is_word_write_f(input ahc_pkg::ahc_cmd_t cmd);
      return cmd == ahc_pkg::CMD_WORD_WRITE || cmd == ahc_pkg::CMD_EXT_WORD_WRITE_B;
   endfunction

   // any write, bit or word, plain or extended
   function automatic logic is_write_f(input ahc_pkg::ahc_cmd_t cmd);
      return is_word_write_f(cmd) || cmd == ahc_pkg::CMD_BIT_WRITE
             || cmd == ahc_pkg::CMD_EXT_WRITE_A;
   endfunction

   // word commands: all but bit access and the link test
   function automatic logic is_word_cmd_f(input ahc_pkg::ahc_cmd_t cmd);
      return cmd != ahc_pkg::CMD_BIT_READ
             && cmd != ahc_pkg::CMD_BIT_WRITE
             && cmd != ahc_pkg::CMD_LINK_TEST;
   endfunction

   // highest device number of an area
   function automatic logic [11:0] area_limit_f(input ahc_pkg::ahc_area_t area);
      logic [11:0] lim;
      // unused area code falls back to the widest limit
      lim = ahc_pkg::MAX_CONSTANT;
      if (area == ahc_pkg::AREA_STATUS_BIT)
      begin
         lim = ahc_pkg::MAX_STATUS_BIT;
      end
      else if (area == ahc_pkg::AREA_CURRENT)
      begin
         lim = ahc_pkg::MAX_CURRENT;
      end
      return lim;
   endfunction

   // one recipe check: a write changing that kind of recipe, state not met
   function automatic logic rcp_fail_f(input logic               wr,
                                       input ahc_pkg::ahc_rcp_t kind,
                                       input ahc_pkg::ahc_rcp_t want,
                                       input logic               state_ok);
      return wr && kind == want && !state_ok;
   endfunction

   // command classes
   wire is_word_write = is_word_write_f(req_i.cmd);
   wire is_write      = is_write_f(req_i.cmd);
   wire is_word_cmd   = is_word_cmd_f(req_i.cmd);
   wire word_dev      = req_i.area != ahc_pkg::AREA_STATUS_BIT;

   // range limit of addressed area and last device touched
   wire [11:0] area_max = area_limit_f(req_i.area);
   wire [12:0] last_dev = {1'b0, req_i.addr} + {5'h00, req_i.count} - 13'h0001;

   // checksum carried against checksum computed by the parser
   wire bad_sum   = req_i.sum_rx != req_i.sum_calc;                         // RL1

   // the parser folds every unknown symbol into one code
   wire bad_cmd   = req_i.cmd == ahc_pkg::CMD_ILLEGAL;                      // RL2

   // link test carries no device number, so it skips the range check
   wire bad_range = req_i.cmd != ahc_pkg::CMD_LINK_TEST
                  && (req_i.addr > area_max || last_dev > {1'b0, area_max}); // RL3

   // status bits refuse word writes; bit writes pass but never store
   wire bad_stat  = is_word_write && !word_dev;                             // RL4 RL12

   // word devices move in pairs: even count, even start
   wire bad_cnt   = is_word_cmd && word_dev && req_i.count[0];             // RL5 RL13
   wire bad_addr  = is_word_cmd && word_dev && req_i.addr[0];              // RL6 RL13

   // state of the requested recipe; out of range counts as unknown
   wire rcp_in   = req_i.rcp_num < RECIPES;
   wire rcp_reg  = rcp_in && registered_ff[req_i.rcp_num];
   wire rcp_meas = rcp_in && rcp_measuring_i[req_i.rcp_num];

   // registration is judged first, so a new recipe never reports 0A or 0B
   wire bad_meas_reg = rcp_fail_f(is_write, req_i.rcp_kind, ahc_pkg::RCP_MEASURE, rcp_reg);  // RL7
   wire bad_disp_reg = rcp_fail_f(is_write, req_i.rcp_kind, ahc_pkg::RCP_DISPLAY, rcp_reg);  // RL8
   wire bad_out_reg  = rcp_fail_f(is_write, req_i.rcp_kind, ahc_pkg::RCP_OUTPUT, rcp_reg);   // RL9

   // a shown or sent recipe must be one under measurement
   wire bad_disp_ms  = rcp_fail_f(is_write, req_i.rcp_kind, ahc_pkg::RCP_DISPLAY, rcp_meas); // RL10
   wire bad_out_ms   = rcp_fail_f(is_write, req_i.rcp_kind, ahc_pkg::RCP_OUTPUT, rcp_meas);  // RL11

   // priority encoder, first failing check wins
   wire [7:0] err_code =
      // framing and symbol
      bad_sum      ? ahc_pkg::ERR_CHECKSUM  :   // RL16
      bad_cmd      ? ahc_pkg::ERR_COMMAND   :
      // addressing
      bad_range    ? ahc_pkg::ERR_RANGE     :
      bad_stat     ? ahc_pkg::ERR_STAT_WR   :
      bad_cnt      ? ahc_pkg::ERR_ODD_COUNT :
      bad_addr     ? ahc_pkg::ERR_ODD_ADDR  :
      // recipe state
      bad_meas_reg ? ahc_pkg::ERR_MEAS_REG  :
      bad_disp_reg ? ahc_pkg::ERR_DISP_REG  :
      bad_out_reg  ? ahc_pkg::ERR_OUT_REG   :
      bad_disp_ms  ? ahc_pkg::ERR_DISP_MEAS :
      bad_out_ms   ? ahc_pkg::ERR_OUT_MEAS  :
                     ahc_pkg::ERR_NONE;
   wire any_err = err_code != ahc_pkg::ERR_NONE;

   // registration flags; a flag once set stays set until reset
   // a request in the cycle of the recipe write still sees the old flag
   for (genvar r = 0; r < RECIPES; r++)
   begin : g_rcp
      logic flag_ff;

      // host write strobe aimed at this recipe number
      assign nxt_registered[r] = flag_ff || (rcp_wr_valid_i && rcp_wr_num_i == 8'(r));

      always_ff @(posedge mclk_i)
      begin
         if (sys_rst_i)
         begin
            flag_ff <= 1'b0;
         end
         else if (clk_en_i)
         begin
            flag_ff <= nxt_registered[r];
         end
      end

      assign registered_ff[r] = flag_ff;
   end

   // verdict handshake, one enabled cycle after the request
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         rsp_valid_ff <= 1'b0;
         go_ff        <= 1'b0;
      end
      else if (clk_en_i)
      begin
         rsp_valid_ff <= req_valid_i;
         go_ff        <= req_valid_i && !any_err;                     // RL16
      end
   end

   // reply byte; back to zero between requests so stale codes never show
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         rsp_ff <= '0;
      end
      else if (clk_en_i)
      begin
         rsp_ff.err  <= req_valid_i && any_err;                     // RL17
         rsp_ff.code <= req_valid_i ? err_code : ahc_pkg::ERR_NONE; // RL17
      end
   end

   // outputs
   assign rsp_valid_o = rsp_valid_ff;
   assign rsp_o       = rsp_ff;
   assign access_go_o = go_ff;
   // status bits are read-only to the host, so no store strobe ever leaves
   assign stat_wr_o   = 1'b0;   // RL12
endmodule

//--- bench/ahc_chk.sv
// checker: verdict timing and code relations at the checker ports
`timescale 1ns/1ps
module ahc_chk #(
   parameter int RECIPES = 256
)(
   // watched ports
   input wire logic               mclk_i,
   input wire logic               sys_rst_i,
   input wire logic               clk_en_i,
   input wire logic               req_valid_i,
   input wire ahc_pkg::ahc_req_t  req_i,
   input wire logic               rcp_wr_valid_i,
   input wire logic [7:0]         rcp_wr_num_i,
   input wire logic [RECIPES-1:0] rcp_measuring_i,
   input wire logic               rsp_valid_o,
   input wire ahc_pkg::ahc_rsp_t  rsp_o,
   input wire logic               access_go_o,
   input wire logic               stat_wr_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // request taken, checksum good, word write into status bits
   wire logic tk = clk_en_i && req_valid_i;
   wire logic ok = req_i.sum_rx == req_i.sum_calc;
   wire logic wrw = req_i.cmd inside {ahc_pkg::CMD_WORD_WRITE, ahc_pkg::CMD_EXT_WORD_WRITE_B};
   wire logic sw = wrw && req_i.area == ahc_pkg::AREA_STATUS_BIT && req_i.addr == 12'h000 && req_i.count == 8'h02;
   // verdict relations
   rsp_lat_a: assert property (tk |=> rsp_valid_o) else $error("no verdict");
   rsp_idle_a: assert property (clk_en_i && !req_valid_i |=> !rsp_valid_o) else $error("stray verdict");
   sum_err_a: assert property (tk && !ok |=> rsp_o == {1'b1, 8'h01}) else $error("bad sum code");
   cmd_err_a: assert property (tk && ok && req_i.cmd == ahc_pkg::CMD_ILLEGAL |=> rsp_o.code == 8'h02)
      else $error("bad command code");
   stat_ww_a: assert property (tk && ok && sw |=> rsp_o.code == 8'h04) else $error("status write code");
   go_err_a: assert property (rsp_valid_o |-> access_go_o == !rsp_o.err) else $error("access on error");
   code_flag_a: assert property (rsp_valid_o |-> rsp_o.err == (rsp_o.code != 8'h00)) else $error("flag");
   no_stat_wr_a: assert property (!stat_wr_o) else $error("status bits written");
   go_cause_a: assert property (access_go_o && $past(clk_en_i) |-> $past(req_valid_i))
      else $error("access without request");
   // main scenarios reached
   cover property (tk && !ok);
   cover property (access_go_o);
   cover property (rsp_valid_o && rsp_o.code == 8'h0B);
endmodule
bind ahc_checker ahc_chk #(.RECIPES(RECIPES)) u_chk (.mclk_i, .sys_rst_i, .clk_en_i, .req_valid_i, .req_i,
   .rcp_wr_valid_i, .rcp_wr_num_i, .rcp_measuring_i, .rsp_valid_o, .rsp_o, .access_go_o, .stat_wr_o);

//--- bench/ahc_host_model.sv
// host model: hands parsed requests to the checker
`timescale 1ns/1ps
module ahc_host_model (
   // clock and orders from the bench
   input  wire logic              mclk_i,
   input  wire logic              send_i,
   input  wire ahc_pkg::ahc_req_t req_in_i,
   // request toward the checker
   output logic                   req_valid_o = 1'b0,
   output ahc_pkg::ahc_req_t      req_o = '0
);
   // one-cycle request; idle fields flip so stale values never pass
   always @(posedge mclk_i)
   begin
      req_valid_o <= send_i;
      req_o       <= send_i ? req_in_i : ~req_o;
   end
endmodule

//--- bench/analyzer_host_command_checker_tb_top.sv
// testbench: directed scenarios for the host command checker
`timescale 1ns/1ps
module analyzer_host_command_checker_tb_top;
   localparam ahc_pkg::ahc_area_t CUR = ahc_pkg::AREA_CURRENT, STA = ahc_pkg::AREA_STATUS_BIT;
   localparam ahc_pkg::ahc_cmd_t RDW = ahc_pkg::CMD_WORD_READ, WRT = ahc_pkg::CMD_WORD_WRITE;
   logic              mclk_i = 1'b0, sys_rst_i = 1'b1, send = 1'b0, rcp_wr_valid_i = 1'b0, clk_en = 1'b1;
   logic [7:0]        rcp_wr_num_i = 8'h00;
   logic [255:0]      rcp_measuring_i = '0;
   ahc_pkg::ahc_req_t req_b = '0, req;
   ahc_pkg::ahc_rsp_t rsp_o;
   logic              req_valid_i, rsp_valid_o, access_go_o, stat_wr_o;
   int                n_fail = 0, n_checks = 0, cyc = 0;
   always #5 mclk_i = ~mclk_i;
   ahc_host_model host (.mclk_i, .send_i(send), .req_in_i(req_b), .req_valid_o(req_valid_i), .req_o(req));
   ahc_checker #(.RECIPES(256)) dut (.mclk_i, .sys_rst_i, .clk_en_i(clk_en), .req_valid_i, .req_i(req),
      .rcp_wr_valid_i, .rcp_wr_num_i, .rcp_measuring_i, .rsp_valid_o, .rsp_o, .access_go_o, .stat_wr_o);
   // compare and count
   task automatic chk(input string nm, input logic [7:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // one request through the host, verdict judged one cycle after it is taken
   task automatic run(input ahc_pkg::ahc_cmd_t c, input ahc_pkg::ahc_area_t a, input logic [11:0] ad,
                      input logic [7:0] n, input ahc_pkg::ahc_rcp_t k, input logic [7:0] e, input logic bad = 0);
      @(posedge mclk_i);
      send  <= 1'b1;
      req_b <= '{8'h5A, bad ? 8'hA5 : 8'h5A, c, a, ad, n, k, 8'h05};
      @(posedge mclk_i);
      send <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk("rsp_valid", {7'h00, rsp_valid_o}, 8'h01);
      chk("code", rsp_o.code, e);
      chk("access_go", {7'h00, access_go_o}, {7'h00, e == 8'h00});
      chk("err", {7'h00, rsp_o.err}, {7'h00, e != 8'h00});
      chk("stat_wr", {7'h00, stat_wr_o}, 8'h00);
   endtask
   // enable low freezes the verdict; it clears on the first enabled edge
   task automatic t_hold;
      @(posedge mclk_i);
      send  <= 1'b1;
      req_b <= '{8'h5A, 8'h5A, RDW, CUR, 12'h000, 8'h03, ahc_pkg::RCP_NONE, 8'h05};
      @(posedge mclk_i);
      send <= 1'b0;
      @(posedge mclk_i);
      clk_en <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1;
      chk("held_valid", {7'h00, rsp_valid_o}, 8'h01);
      chk("held_code", rsp_o.code, 8'h05);
      @(posedge mclk_i);
      clk_en <= 1'b1;
      @(posedge mclk_i);
      #1;
      chk("released_valid", {7'h00, rsp_valid_o}, 8'h00);
   endtask
   // checksum outranks unknown command; all symbols
   task automatic t_cmd;
      run(ahc_pkg::CMD_ILLEGAL, CUR, 12'h000, 8'h02, ahc_pkg::RCP_NONE, 8'h01, 1'b1);
      for (int i = 0; i < 9; i++)
         run(ahc_pkg::ahc_cmd_t'(i), CUR, 12'h000, 8'h02, ahc_pkg::RCP_NONE, 8'h00);
      run(ahc_pkg::CMD_ILLEGAL, CUR, 12'h000, 8'h02, ahc_pkg::RCP_NONE, 8'h02);
   endtask
   // range edge, status writes, alignment
   task automatic t_area;
      run(RDW, CUR, 12'h09E, 8'h02, ahc_pkg::RCP_NONE, 8'h00);
      run(RDW, CUR, 12'h0A0, 8'h02, ahc_pkg::RCP_NONE, 8'h03);
      run(WRT, STA, 12'h000, 8'h02, ahc_pkg::RCP_NONE, 8'h04);
      run(ahc_pkg::CMD_EXT_WORD_WRITE_B, STA, 12'h000, 8'h02, ahc_pkg::RCP_NONE, 8'h04);
      run(RDW, CUR, 12'h000, 8'h03, ahc_pkg::RCP_NONE, 8'h05);
      run(RDW, CUR, 12'h001, 8'h02, ahc_pkg::RCP_NONE, 8'h06);
      run(WRT, CUR, 12'h001, 8'h03, ahc_pkg::RCP_NONE, 8'h05);
   endtask
   // recipe registration, measurement, and a reset that forgets the registration
   task automatic t_rcp;
      run(WRT, CUR, 12'h000, 8'h02, ahc_pkg::RCP_MEASURE, 8'h07);
      run(WRT, CUR, 12'h000, 8'h02, ahc_pkg::RCP_DISPLAY, 8'h08);
      run(WRT, CUR, 12'h000, 8'h02, ahc_pkg::RCP_OUTPUT, 8'h09);
      @(posedge mclk_i);
      rcp_wr_valid_i <= 1'b1;
      rcp_wr_num_i   <= 8'h05;
      @(posedge mclk_i);
      rcp_wr_valid_i <= 1'b0;
      run(WRT, CUR, 12'h000, 8'h02, ahc_pkg::RCP_DISPLAY, 8'h0A);
      run(WRT, CUR, 12'h000, 8'h02, ahc_pkg::RCP_OUTPUT, 8'h0B);
      run(WRT, CUR, 12'h000, 8'h02, ahc_pkg::RCP_MEASURE, 8'h00);
      @(posedge mclk_i);
      rcp_measuring_i[5] <= 1'b1;
      run(WRT, CUR, 12'h000, 8'h02, ahc_pkg::RCP_OUTPUT, 8'h00);
      @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      run(WRT, CUR, 12'h000, 8'h02, ahc_pkg::RCP_DISPLAY, 8'h08);
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      t_cmd;
      t_area;
      t_rcp;
      t_hold;
      give_verdict;
   end
   // hang guard
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_fail++;
         give_verdict;
      end
   end
endmodule
